// ---- bench/bas_front_model.sv ----
// front panel and sensor side model: thumbwheel-free readings and the silence button
// assumes the bench sets the wanted levels; the model hands them on at the next clock edge
`timescale 1ns/1ns
module bas_front_model (
  input wire logic clk,
  input wire logic [15:0] wantBat,
  input wire logic [15:0] wantSup,
  input wire logic wantExt,
  input wire logic [7:0] wantNo,
  input wire logic [7:0] wantNo2,
  input wire logic wantSil,
  output logic [15:0] batteryMv = 16'h1964,
  output logic [15:0] supplyMv = 16'h1388,
  output logic extPower = 1'b1,
  output logic [7:0] noPpm = 8'h00,
  output logic [7:0] no2Ppm = 8'h00,
  output logic silencePress = 1'b0
);
  // readings move only on a clock edge, as a sampled converter would deliver them
  always @(posedge clk) begin
    batteryMv <= wantBat;
    supplyMv <= wantSup;
    extPower <= wantExt;
    noPpm <= wantNo;
    no2Ppm <= wantNo2;
    silencePress <= wantSil;
  end
endmodule : bas_front_model

// ---- bench/battery_alarm_supervisor_tb.sv ----
// self-checking bench for the supervisor: power, battery, limits, alarms, faults
// assumes the designer's one-wait-state APB slave and shortened silence and dwell counts
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp=%h got=%h", nm, ex, got); end end
module battery_alarm_supervisor_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext = 1, sil = 0, err, nOn;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, controllerReset, nitricEnable, audibleAlarm, extPower, silencePress;
  logic [15:0] bat = 16'h1964, sup = 16'h1388, batteryMv, supplyMv;
  logic [7:0] no = 0, no2 = 0, noPpm, no2Ppm, hi, lo, h2, g, g2, seen;
  bas_pkg::bas_glyph_t glyph;
  bas_pkg::bas_msg_t message;
  bas_pkg::bas_alarm_t visibleAlarm, ea;
  int bad_count = 0, checks_done = 0;
  integer seed = 32'h7b14;
  localparam logic [15:0] BANDS [5] = '{16'h1770, 16'h16A8, 16'h15E0, 16'h1389, 16'h1388};
  always #5 clk = ~clk;
  bas_front_model i_bas_front_model (.clk(clk), .wantBat(bat), .wantSup(sup), .wantExt(ext),
    .wantNo(no), .wantNo2(no2), .wantSil(sil), .batteryMv(batteryMv), .supplyMv(supplyMv),
    .extPower(extPower), .noPpm(noPpm), .no2Ppm(no2Ppm), .silencePress(silencePress));
  battery_alarm_supervisor #(.SILENCE_CYCLES(100), .MSG_DWELL_CYCLES(4))
  i_battery_alarm_supervisor (
    .clk(clk), .rst(rst), .batteryMv(batteryMv), .supplyMv(supplyMv), .extPower(extPower),
    .noPpm(noPpm), .no2Ppm(no2Ppm), .silencePress(silencePress), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .glyph(glyph), .message(message),
    .controllerReset(controllerReset), .nitricEnable(nitricEnable),
    .audibleAlarm(audibleAlarm), .visibleAlarm(visibleAlarm));
  // ---------------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] clamp12(input logic [7:0] v);
    return (v > 8'h0C) ? 8'h0C : v;
  endfunction : clamp12
  function automatic logic [7:0] hh_no(input logic [7:0] v);
    return (v > 8'h5F) ? 8'h64 : v + 8'h05;
  endfunction : hh_no
  // ---------------------------------------------------------------------------
  // bus and run control
  // ---------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    #500_000;
    bad_count++;
    stop_test();
  end
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    `CHK("rstHold", 1'b1, controllerReset)
    `CHK("rstNitric", 1'b0, nitricEnable)
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK("inputsRst", 32'h0000_0000, rd)
    `CHK("plug", bas_pkg::BAS_GLYPH_PLUG, glyph)
    ext <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bat <= BANDS[i];
      settle();
      `CHK("band", bas_pkg::bas_glyph_t'(i + 1), glyph)
    end
    `CHK("lowBat", bas_pkg::BAS_MSG_LOW_BAT, message)
    // critical battery: all three messages must show while delivery stays off
    bat <= 16'h1324;
    settle();
    seen = 8'h00;
    nOn = 1'b0;
    repeat (40) begin
      @(posedge clk);
      seen[message] = 1'b1;
      nOn |= nitricEnable;
    end
    `CHK("critSeq", 8'h1C, seen)
    `CHK("critNitric", 1'b0, nOn)
    sup <= 16'h11F8;
    settle();
    `CHK("supLow", 1'b1, controllerReset)
    sup <= 16'h11F9;
    settle();
    `CHK("supOk", 1'b0, controllerReset)
    ext <= 1'b1;
    bat <= 16'h1964;
    // limits and alarms, corners first: top of the NO range and the NO2 clamp edge
    for (int i = 0; i < 30; i++) begin
      hi = 8'($unsigned($random(seed)) % 100);
      lo = 8'($unsigned($random(seed)) % 100);
      h2 = 8'($unsigned($random(seed)) % 100);
      g = 8'($unsigned($random(seed)) % 110);
      g2 = 8'($unsigned($random(seed)) % 20);
      if (i < 2) begin
        hi = 8'h63;
        h2 = 8'h0B + 8'(i);
        g = 8'h64 + 8'(i);
        g2 = 8'h0C;
      end
      apb(1'b1, 32'h0000_0000, {8'h00, h2, lo, hi});
      no <= g;
      no2 <= g2;
      settle();
      apb(1'b0, 32'h0000_0000, 32'h0000_0000);
      `CHK("inputs", {8'h00, h2, lo, hi}, rd)
      apb(1'b0, 32'h0000_0004, 32'h0000_0000);
      `CHK("limits", {clamp12(clamp12(h2) + 8'h01), hh_no(hi), lo, clamp12(h2)}, rd)
      ea = '{g > hi, g < lo, g2 > clamp12(h2), g > hh_no(hi), g2 > clamp12(clamp12(h2) + 8'h01)};
      `CHK("visible", ea, visibleAlarm)
      `CHK("audible", |ea, audibleAlarm)
      `CHK("nitric", !(ea.noHighHigh | ea.no2HighHigh), nitricEnable)
      `CHK("msgOff", (ea.noHighHigh | ea.no2HighHigh) ? bas_pkg::BAS_MSG_NITRIC_OFF :
        bas_pkg::BAS_MSG_NONE, message)
    end
    no <= 8'h00;
    no2 <= 8'h00;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 32'h0000_0000, {5'h00, 3'(1 << k), 24'h00_0032});
      settle();
      `CHK("fault", bas_pkg::bas_msg_t'(5 + k), message)
    end
    // silence mutes sound only, and only for the shortened count
    apb(1'b1, 32'h0000_0000, 32'h0000_000A);
    no <= 8'h32;
    settle();
    `CHK("alarmOn", 1'b1, audibleAlarm)
    sil <= 1'b1;
    @(posedge clk);
    sil <= 1'b0;
    repeat (50) @(posedge clk);
    `CHK("muted", 1'b0, audibleAlarm)
    `CHK("stillSeen", 1'b1, visibleAlarm.noHigh)
    repeat (60) @(posedge clk);
    `CHK("unmuted", 1'b1, audibleAlarm)
    // NO 50 over high 10 and high-high 15: delivery off, plug glyph on external power
    apb(1'b0, 32'h0000_0008, 32'h0000_0000);
    `CHK("status", {16'h0000, 5'b10010, 4'b0001, bas_pkg::BAS_MSG_NITRIC_OFF, bas_pkg::BAS_GLYPH_PLUG}, rd)
    apb(1'b0, 32'h0000_0040, 32'h0000_0000);
    `CHK("badAddrErr", 1'b1, err)
    `CHK("badAddrData", 32'h0000_0000, rd)
    stop_test();
  end
endmodule : battery_alarm_supervisor_tb

// ---- logic/bas_pkg.sv ----
// package for the battery and alarm supervisor
// assumes a single 100 MHz clock domain and APB register access
package bas_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SILENCE_SEC = 60;
  localparam longint SILENCE_CYCLES = longint'(SILENCE_SEC) * 1000000 * CLK_MHZ;
  localparam int MSG_DWELL_MS = 1000;
  localparam longint MSG_DWELL_CYCLES = longint'(MSG_DWELL_MS) * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------------------
  // thresholds, millivolts
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LOW_BAT_MV = 16'h1388;
  localparam logic [15:0] CRIT_BAT_MV = 16'h1324;
  localparam logic [15:0] RESET_MV = 16'h11F8;
  localparam logic [15:0] FULL_BAT_MV = 16'h1770;

  // ---------------------------------------------------------------------------
  // limits, ppm
  // ---------------------------------------------------------------------------
  localparam logic [7:0] NO2_HI_MAX = 8'h0C;
  localparam logic [7:0] NO_HH_OFFSET = 8'h05;
  localparam logic [7:0] NO2_HH_OFFSET = 8'h01;
  localparam logic [7:0] NO_HH_MAX = 8'h64;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_INPUTS = 8'h00;
  localparam logic [7:0] REG_LIMITS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FAULTS = 8'h0C;
  localparam logic [31:0] INPUTS_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // messages and glyphs
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    BAS_MSG_NONE, BAS_MSG_LOW_BAT, BAS_MSG_DATA_INVALID, BAS_MSG_CONNECT_CHARGER,
    BAS_MSG_NITRIC_OFF, BAS_MSG_NO_ZERO_FAIL, BAS_MSG_NO2_ZERO_FAIL, BAS_MSG_ROM_FAIL
  } bas_msg_t;

  typedef enum logic [2:0] {
    BAS_GLYPH_PLUG, BAS_GLYPH_B_FULL, BAS_GLYPH_B_3Q, BAS_GLYPH_B_HALF,
    BAS_GLYPH_B_1Q, BAS_GLYPH_B_EMPTY
  } bas_glyph_t;

  typedef struct packed {
    logic noHigh;
    logic noLow;
    logic no2High;
    logic noHighHigh;
    logic no2HighHigh;
  } bas_alarm_t;

endpackage : bas_pkg

// ---- logic/battery_alarm_supervisor.sv ----
// battery and gas alarm supervisor with APB register access
// assumes supply, battery and gas readings arrive already digitised and synchronous to clk
`timescale 1ns/1ns
module battery_alarm_supervisor #(
  parameter longint SILENCE_CYCLES = bas_pkg::SILENCE_CYCLES,
  parameter longint MSG_DWELL_CYCLES = bas_pkg::MSG_DWELL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] batteryMv,
  input wire logic [15:0] supplyMv,
  input wire logic extPower,
  input wire logic [7:0] noPpm,
  input wire logic [7:0] no2Ppm,
  input wire logic silencePress,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output bas_pkg::bas_glyph_t glyph,
  output bas_pkg::bas_msg_t message,
  output logic controllerReset,
  output logic nitricEnable,
  output logic audibleAlarm,
  output bas_pkg::bas_alarm_t visibleAlarm
);

  // ---------------------------------------------------------------------------
  // apb slave: inputs reg = {faults[26:24], no2Hi, noLo, noHi}
  // ---------------------------------------------------------------------------
  logic [31:0] inputsReg;
  logic apbAccess;
  logic addrOk;
  assign apbAccess = psel && penable && !pready;
  assign addrOk = paddr[31:4] == 28'h000_0000 && paddr[1:0] == 2'b00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !addrOk;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inputsReg <= bas_pkg::INPUTS_RST;
    end else if (apbAccess && pwrite && paddr[7:0] == bas_pkg::REG_INPUTS && addrOk) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          inputsReg[i*8 +: 8] <= pwdata[i*8 +: 8];
        end
      end
    end
  end

  function automatic logic [7:0] bcdLimit(input logic [7:0] v);
    // a setting beyond 99 cannot come from a thumbwheel; clip it to stay in range
    bcdLimit = (v > 8'h63) ? 8'h63 : v;
  endfunction : bcdLimit

  logic [7:0] noHi;
  logic [7:0] noLo;
  logic [7:0] no2Hi;
  logic [7:0] no2Clamped;
  logic [7:0] noHh;
  logic [7:0] no2Hh;
  assign noHi = bcdLimit(inputsReg[7:0]);
  assign noLo = bcdLimit(inputsReg[15:8]);
  assign no2Hi = bcdLimit(inputsReg[23:16]);
  assign no2Clamped = (no2Hi > bas_pkg::NO2_HI_MAX) ? bas_pkg::NO2_HI_MAX : no2Hi;

  always_comb begin
    logic [7:0] sumNo;
    logic [7:0] sumNo2;
    sumNo = noHi + bas_pkg::NO_HH_OFFSET;
    sumNo2 = no2Clamped + bas_pkg::NO2_HH_OFFSET;
    noHh = (sumNo > bas_pkg::NO_HH_MAX) ? bas_pkg::NO_HH_MAX : sumNo;
    no2Hh = (sumNo2 > bas_pkg::NO2_HI_MAX) ? bas_pkg::NO2_HI_MAX : sumNo2;
  end

  logic noZeroFault;
  logic no2ZeroFault;
  logic romFault;
  assign noZeroFault = inputsReg[24];
  assign no2ZeroFault = inputsReg[25];
  assign romFault = inputsReg[26];

  // ---------------------------------------------------------------------------
  // battery and supply
  // ---------------------------------------------------------------------------
  logic lowBat;
  logic critBat;
  assign lowBat = !extPower && batteryMv <= bas_pkg::LOW_BAT_MV;
  assign critBat = !extPower && batteryMv <= bas_pkg::CRIT_BAT_MV;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      controllerReset <= 1'b1;
    end else begin
      controllerReset <= supplyMv <= bas_pkg::RESET_MV;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      glyph <= bas_pkg::BAS_GLYPH_PLUG;
    end else if (extPower) begin
      glyph <= bas_pkg::BAS_GLYPH_PLUG;
    end else if (batteryMv >= bas_pkg::FULL_BAT_MV) begin
      glyph <= bas_pkg::BAS_GLYPH_B_FULL;
    end else if (batteryMv >= 16'h16A8) begin
      glyph <= bas_pkg::BAS_GLYPH_B_3Q;
    end else if (batteryMv >= 16'h15E0) begin
      glyph <= bas_pkg::BAS_GLYPH_B_HALF;
    end else if (batteryMv > bas_pkg::LOW_BAT_MV) begin
      glyph <= bas_pkg::BAS_GLYPH_B_1Q;
    end else begin
      glyph <= bas_pkg::BAS_GLYPH_B_EMPTY;
    end
  end

  // ---------------------------------------------------------------------------
  // alarms
  // ---------------------------------------------------------------------------
  bas_pkg::bas_alarm_t alarmNow;
  // one process drives the whole struct, so it keeps a single driver
  always_comb begin
    alarmNow.noHigh = noPpm > noHi;
    alarmNow.noLow = noPpm < noLo;
    alarmNow.no2High = no2Ppm > no2Clamped;
    alarmNow.noHighHigh = noPpm > noHh;
    alarmNow.no2HighHigh = no2Ppm > no2Hh;
  end

  logic [47:0] silenceCount;
  logic silenced;
  assign silenced = silenceCount != 48'h0000_0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      silenceCount <= 48'h0000_0000_0000;
    end else if (silencePress) begin
      silenceCount <= SILENCE_CYCLES[47:0];
    end else if (silenced) begin
      silenceCount <= silenceCount - 48'h0000_0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      visibleAlarm <= '0;
      audibleAlarm <= 1'b0;
      nitricEnable <= 1'b0;
    end else begin
      visibleAlarm <= alarmNow;
      audibleAlarm <= (|alarmNow) && !silenced && !silencePress;
      // delivery resumes on its own once readings drop back under the high-high limits and the battery is not critical
      nitricEnable <= !(alarmNow.noHighHigh || alarmNow.no2HighHigh) && !critBat;
    end
  end

  // ---------------------------------------------------------------------------
  // message sequencer
  // ---------------------------------------------------------------------------
  logic [39:0] dwellCount;
  logic [1:0] critPhase;
  logic dwellDone;
  assign dwellDone = dwellCount >= MSG_DWELL_CYCLES[39:0] - 40'h00_0000_0001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dwellCount <= 40'h00_0000_0000;
      critPhase <= 2'b00;
    end else if (!critBat) begin
      dwellCount <= 40'h00_0000_0000;
      critPhase <= 2'b00;
    end else if (dwellDone) begin
      dwellCount <= 40'h00_0000_0000;
      critPhase <= (critPhase == 2'b10) ? 2'b00 : critPhase + 2'b01;
    end else begin
      dwellCount <= dwellCount + 40'h00_0000_0001;
    end
  end

  bas_pkg::bas_msg_t next_message;
  always_comb begin
    next_message = bas_pkg::BAS_MSG_NONE;
    if (critBat) begin
      case (critPhase)
        2'b00: next_message = bas_pkg::BAS_MSG_DATA_INVALID;
        2'b01: next_message = bas_pkg::BAS_MSG_CONNECT_CHARGER;
        default: next_message = bas_pkg::BAS_MSG_NITRIC_OFF;
      endcase
    end else if (romFault) begin
      next_message = bas_pkg::BAS_MSG_ROM_FAIL;
    end else if (noZeroFault) begin
      next_message = bas_pkg::BAS_MSG_NO_ZERO_FAIL;
    end else if (no2ZeroFault) begin
      next_message = bas_pkg::BAS_MSG_NO2_ZERO_FAIL;
    end else if (alarmNow.noHighHigh || alarmNow.no2HighHigh) begin
      next_message = bas_pkg::BAS_MSG_NITRIC_OFF;
    end else if (lowBat) begin
      next_message = bas_pkg::BAS_MSG_LOW_BAT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      message <= bas_pkg::BAS_MSG_NONE;
    end else begin
      message <= next_message;
    end
  end

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apbAccess && !pwrite) begin
      case (paddr[7:0])
        bas_pkg::REG_INPUTS: prdata <= inputsReg;
        bas_pkg::REG_LIMITS: prdata <= {no2Hh, noHh, noLo, no2Clamped};
        // 16 + 5 + 4 + 4 + 3 bits: exactly one word, alarms in [15:11]
        bas_pkg::REG_STATUS: prdata <= {16'h0000, visibleAlarm, nitricEnable,
                                        critBat, lowBat, extPower, message, glyph};
        bas_pkg::REG_FAULTS: prdata <= {29'h0000_0000, romFault, no2ZeroFault, noZeroFault};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_plug;
    @(posedge clk) disable iff (rst) extPower |=> glyph == bas_pkg::BAS_GLYPH_PLUG;
  endproperty
  a_plug: assert property (p_plug) else $error("plug glyph missing");

  property p_empty;
    @(posedge clk) disable iff (rst)
      (!extPower && batteryMv <= bas_pkg::LOW_BAT_MV) |=> glyph == bas_pkg::BAS_GLYPH_B_EMPTY;
  endproperty
  a_empty: assert property (p_empty) else $error("battery glyph not empty");

  property p_lowbat;
    @(posedge clk) disable iff (rst)
      (lowBat && !critBat && !romFault && !(|inputsReg[25:24]) && !alarmNow.noHighHigh
       && !alarmNow.no2HighHigh) |=> message == bas_pkg::BAS_MSG_LOW_BAT;
  endproperty
  a_lowbat: assert property (p_lowbat) else $error("low battery message missing");

  property p_critseq;
    @(posedge clk) disable iff (rst)
      (critBat && critPhase == 2'b00) |=> message == bas_pkg::BAS_MSG_DATA_INVALID;
  endproperty
  a_critseq: assert property (p_critseq) else $error("critical sequence wrong");

  property p_reset;
    @(posedge clk) disable iff (rst) (supplyMv <= bas_pkg::RESET_MV) |=> controllerReset;
  endproperty
  a_reset: assert property (p_reset) else $error("controller reset not held");

  property p_no2clamp;
    @(posedge clk) disable iff (rst) no2Clamped <= bas_pkg::NO2_HI_MAX && no2Hh <= 8'h0C;
  endproperty
  a_no2clamp: assert property (p_no2clamp) else $error("no2 limit above 12");

  property p_nohh;
    @(posedge clk) disable iff (rst) noHh == ((noHi > 8'h5F) ? 8'h64 : noHi + 8'h05);
  endproperty
  a_nohh: assert property (p_nohh) else $error("no high-high limit wrong");

  property p_cut;
    @(posedge clk) disable iff (rst) (noPpm > noHh || no2Ppm > no2Hh || critBat) |=> !nitricEnable;
  endproperty
  a_cut: assert property (p_cut) else $error("nitric not cut");

  property p_silence;
    @(posedge clk) disable iff (rst) silencePress |=> !audibleAlarm [*8];
  endproperty
  a_silence: assert property (p_silence) else $error("audible not muted");

  property p_visible;
    @(posedge clk) disable iff (rst) (noPpm > noHi) |=> visibleAlarm.noHigh;
  endproperty
  a_visible: assert property (p_visible) else $error("visible alarm missing");

  c_crit: cover property (@(posedge clk) disable iff (rst) critBat ##1 critPhase == 2'b01);
  c_cut: cover property (@(posedge clk) disable iff (rst) nitricEnable ##1 !nitricEnable);
  c_alarm: cover property (@(posedge clk) disable iff (rst) audibleAlarm ##1 silencePress);
  c_write: cover property (@(posedge clk) disable iff (rst) apbAccess && pwrite);

endmodule : battery_alarm_supervisor
